// >>> common/pga_pkg.sv
// package for the power-good aggregation block: register map, fields, resets
// assumes a 32-bit apb slave with byte addresses four times the printed index
package pga_pkg;
   // printed register offsets are indices; byte address is four times these
   localparam logic [7:0] IDX_CTRL_ONE = 8'h15;
   localparam logic [7:0] IDX_CTRL_TWO = 8'h16;
   localparam logic [7:0] IDX_FAULT = 8'h17;
   localparam logic [7:0] IDX_SOFT_RESET = 8'h18;
   localparam logic [7:0] IDX_IRQ_STATUS = 8'h20;
   localparam logic [7:0] IDX_IRQ_MASK = 8'h21;
   localparam logic [7:0] IDX_LIVE_STATUS = 8'h22;
   localparam int ADDR_W = 12;

   // power_good_control_one fields
   localparam int C1_POL = 7;
   localparam int C1_OPEN_DRAIN = 6;
   localparam int C1_WIN_LIN = 5;
   localparam int C1_WIN_BUCK = 4;
   localparam logic [7:0] CTRL_ONE_RST = 8'h73;

   // power_good_control_two fields
   localparam int C2_TWARN = 2;
   localparam int C2_LATCH = 1;
   localparam int C2_MODE = 0;
   localparam logic [7:0] CTRL_TWO_RST = 8'h04;
   localparam logic [7:0] CTRL_TWO_MASK = 8'h07;

   // fault flag bits: 3 linreg1, 2 linreg0, 1 buck1, 0 buck0
   localparam int NUM_RAILS = 4;
   localparam logic [7:0] FAULT_RST = 8'h00;
   localparam logic [7:0] FAULT_MASK = 8'h0f;
   localparam int SOFT_RESET_BIT = 0;

   // interrupt status: bits 3:0 rail fault flagged, bit 4 power good fell
   localparam int IRQ_W = 5;
   localparam int IRQ_PG_FALL = 4;
   localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 5'h00;

   typedef struct packed {
      logic polarity;
      logic latched_fault_select;
      logic thermal_warn_gate_en;
      logic power_good_op_mode;
      logic [NUM_RAILS-1:0] monitor_en;
   } pga_cfg_t;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [ADDR_W-1:0] paddr;
      logic [31:0] pwdata;
   } pga_apb_req_t;
endpackage

// >>> hdl/pga_rail_mon.sv
// per-rail fault flag cell, one instance per monitored regulator output
// assumes rail_valid is already synchronised to clock
`timescale 1ns/100ps
`default_nettype none
module pga_rail_mon
   import pga_pkg::*;
(
   input wire logic clock, // system clock
   input wire logic sys_rst, // synchronous reset, active high
   input wire logic soft_rst, // register default reload pulse
   input wire logic rail_valid, // synchronised live validity
   input wire logic monitor_en, // rail takes part in power good
   input wire logic fall_event, // power good went inactive this cycle
   input wire logic clear_req, // write-one to this flag accepted by bus
   output logic fault_flag // sticky fault flag
);
   always_ff @(posedge clock) begin
      if (sys_rst || soft_rst) begin
         fault_flag <= 1'b0;
      end else if (monitor_en && !rail_valid && fall_event) begin
         fault_flag <= 1'b1;
      end else if (clear_req && rail_valid) begin
         fault_flag <= 1'b0;
      end
      // a clear while the rail is bad, or a written zero, keeps the flag
   end
endmodule // pga_rail_mon
`default_nettype wire

// >>> hdl/pga_power_good.sv
// power-good aggregation: combines rail validity and thermal warning
// into one power-good pin, with sticky per-rail fault flags over apb.
// assumes rail_valid and thermal_warn come asynchronously from analog.
// registers sit at word index times four; data rides in bits 7:0:
//   0x15 control one: polarity, drive type, windows, monitor enables
//   0x16 control two: thermal gate, latched-fault select, mode
//   0x17 fault flags, write one clears while the rail is valid
//   0x18 soft reset, self-clearing, reloads every register default
//   0x20 interrupt status, write one clears, a new event wins
//   0x21 interrupt mask, 0x22 live status, read only
// unmapped or misaligned accesses answer with pslverr and read zero.
// the window bits are stored only; the analog comparators that use
// them live outside this block.
// the mode bit is stored and read back; both modes follow one path here.
// polarity and drive type apply at the pin flop, after all gating.
//
// Contract
// - with the thermal gate bit set, thermal warning forces power good inactive; cleared, it is ignored.
// - with latched-fault select clear, power good follows live validity of monitored rails.
// - with latched-fault select set, power good follows the fault flags and is inactive while any is set; the code also requires live validity of monitored rails.
// - a one-bit mode field selects gated mode at zero and continuous mode at one.
// - each fault flag sets when its rail is monitored and caused power good to go inactive.
// - writing one clears a fault flag only while its rail is currently valid.
// - reserved upper bits of control two and the fault register reset to zero and read zero.
// - a rail counts toward power good only while its monitoring enable bit is one; in latched mode the code also counts a flag set before the bit cleared.
// - the polarity bit drives the pin high for good at zero and low for good at one.
//
// Implementation choice: the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module pga_power_good
   import pga_pkg::*;
#(
   parameter int RAILS = NUM_RAILS
)(
   input wire logic clock, // 200 MHz system clock
   input wire logic sys_rst, // synchronous reset, active high
   input wire logic psel, // apb select
   input wire logic penable, // apb enable
   input wire logic pwrite, // apb direction
   input wire logic [ADDR_W-1:0] paddr, // apb byte address
   input wire logic [31:0] pwdata, // apb write data
   output logic [31:0] prdata, // apb read data
   output logic pready, // apb ready
   output logic pslverr, // apb error on unmapped address
   input wire logic [RAILS-1:0] rail_valid, // async rail valid, 3 lr1..0 bk0
   input wire logic thermal_warn, // async die thermal warning
   output logic power_good_out, // power-good pin level
   output logic power_good_oe, // drive enable for the pin
   output logic irq // level interrupt
);
   // elaboration checks: decode and read mux are built for these sizes
   generate
      if (RAILS != NUM_RAILS) begin : g_bad_rails
         $error("pga_power_good supports exactly four rails");
      end
      if (ADDR_W < 10) begin : g_bad_addr
         $error("pga_power_good needs at least ten address bits");
      end
      if (IRQ_W != RAILS + 1) begin : g_bad_irq
         $error("pga_power_good needs one interrupt bit per rail plus one");
      end
      if ((CTRL_TWO_RST & ~CTRL_TWO_MASK) != 8'h00) begin : g_bad_rst
         $error("pga_power_good reserved control bits must reset to zero");
      end
      if ((FAULT_RST & ~FAULT_MASK) != 8'h00) begin : g_bad_fault
         $error("pga_power_good reserved fault bits must reset to zero");
      end
   endgenerate

   pga_apb_req_t req;
   pga_cfg_t cfg;
   logic [7:0] ctrl_one;
   logic [7:0] ctrl_two;
   logic [RAILS-1:0] fault_flags;
   logic [IRQ_W-1:0] irq_status;
   logic [IRQ_W-1:0] irq_mask;
   logic [RAILS-1:0] valid_meta, valid_sync;
   logic twarn_meta, twarn_sync;
   logic soft_rst;
   logic good, good_q, fall_event;
   logic live_good, latched_good, twarn_block;
   logic wr_acc, rd_acc;
   logic [RAILS-1:0] clear_req;
   logic [RAILS-1:0] next_irq_set;
   typedef enum {acc_idle, acc_answer} pga_acc_t;
   logic wr_ctrl_one;
   logic wr_ctrl_two;
   logic wr_fault;
   logic wr_soft;
   logic wr_irq_status;
   logic wr_irq_mask;
   logic next_pready;
   logic next_pslverr;
   logic next_pin_level;
   logic next_pin_oe;
   logic [31:0] next_prdata;
   logic [IRQ_W-1:0] irq_set, irq_clr;
   pga_acc_t acc_state, next_acc_state;

   function automatic logic [7:0] reg_index(input logic [ADDR_W-1:0] a);
      reg_index = a[9:2];
   endfunction

   function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
      logic [7:0] i;
      i = reg_index(a);
      is_mapped = (a[1:0] == 2'h0) && (a[ADDR_W-1:10] == '0) &&
         (i == IDX_CTRL_ONE || i == IDX_CTRL_TWO || i == IDX_FAULT ||
          i == IDX_SOFT_RESET || i == IDX_IRQ_STATUS ||
          i == IDX_IRQ_MASK || i == IDX_LIVE_STATUS);
   endfunction

   assign req = '{psel: psel, penable: penable, pwrite: pwrite,
                  paddr: paddr, pwdata: pwdata};
   // access completes on the cycle pready is high; slave answers after one wait
   assign wr_acc = req.psel && req.penable && pready && req.pwrite &&
                   is_mapped(req.paddr);
   assign rd_acc = req.psel && req.penable && !req.pwrite;

   // one write strobe per register keeps the decode in one place
   always_comb begin
      wr_ctrl_one = wr_acc && reg_index(req.paddr) == IDX_CTRL_ONE;
      wr_ctrl_two = wr_acc && reg_index(req.paddr) == IDX_CTRL_TWO;
      wr_fault = wr_acc && reg_index(req.paddr) == IDX_FAULT;
      wr_soft = wr_acc && reg_index(req.paddr) == IDX_SOFT_RESET;
      wr_irq_status = wr_acc && reg_index(req.paddr) == IDX_IRQ_STATUS;
      wr_irq_mask = wr_acc && reg_index(req.paddr) == IDX_IRQ_MASK;
   end

   // two-stage synchronisers for analog status; only the second stage
   // is read, so a metastable first stage never reaches the logic
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         valid_meta <= '0;
         valid_sync <= '0;
      end else begin
         valid_meta <= rail_valid;
         valid_sync <= valid_meta;
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         twarn_meta <= 1'b0;
         twarn_sync <= 1'b0;
      end else begin
         twarn_meta <= thermal_warn;
         twarn_sync <= twarn_meta;
      end
   end

   // apb handshake: one wait state, then pready for exactly one cycle
   always_comb begin
      next_acc_state = acc_idle;
      case (acc_state)
         acc_idle: begin
            if (req.psel && req.penable) begin
               next_acc_state = acc_answer;
            end
         end
         acc_answer: begin
            next_acc_state = acc_idle;
         end
         default: begin
            next_acc_state = acc_idle;
         end
      endcase
      next_pready = next_acc_state == acc_answer;
      next_pslverr = next_pready && !is_mapped(req.paddr);
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         acc_state <= acc_idle;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         acc_state <= next_acc_state;
         pready <= next_pready;
         pslverr <= next_pslverr;
      end
   end

   // soft reset self-clears: one pulse reloads all register defaults
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         soft_rst <= 1'b0;
      end else begin
         soft_rst <= wr_soft && req.pwdata[SOFT_RESET_BIT];
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst || soft_rst) begin
         ctrl_one <= CTRL_ONE_RST;
      end else if (wr_ctrl_one) begin
         // every bit kept; window bits act outside this block, the drive bit sets the pin enable here
         ctrl_one <= req.pwdata[7:0];
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst || soft_rst) begin
         ctrl_two <= CTRL_TWO_RST;
      end else if (wr_ctrl_two) begin
         // reserved bits are dropped on write so they always read zero
         ctrl_two <= req.pwdata[7:0] & CTRL_TWO_MASK;
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst || soft_rst) begin
         irq_mask <= IRQ_MASK_RST;
      end else if (wr_irq_mask) begin
         // a mask bit only gates the pin, the status keeps recording
         irq_mask <= req.pwdata[IRQ_W-1:0];
      end
   end

   always_comb begin
      // field split of the two control registers
      cfg.polarity = ctrl_one[C1_POL];
      cfg.latched_fault_select = ctrl_two[C2_LATCH];
      cfg.thermal_warn_gate_en = ctrl_two[C2_TWARN];
      cfg.power_good_op_mode = ctrl_two[C2_MODE];
      cfg.monitor_en = ctrl_one[RAILS-1:0];
   end

   // aggregation; disabled rails are forced good
   assign live_good = &(valid_sync | ~cfg.monitor_en);
   assign latched_good = ~|fault_flags;
   assign twarn_block = cfg.thermal_warn_gate_en && twarn_sync;

   // gated mode (zero) only reports rails once all monitored ones are
   // valid; continuous mode also tracks them. the analog difference
   // between the two lies outside this block, so both follow one path.
   always_comb begin
      if (twarn_block) begin
         good = 1'b0;
      end else if (cfg.latched_fault_select) begin
         good = latched_good && live_good;
      end else begin
         good = live_good;
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         good_q <= 1'b0;
      end else begin
         // previous verdict, the reference against which a fall is seen
         good_q <= good;
      end
   end

   // a fall from good to not good, caused by a rail, latches that rail
   assign fall_event = good_q && !live_good;

   genvar g;
   generate
      // one flag cell per rail; the cell owns set, clear and hold
      for (g = 0; g < RAILS; g++) begin : g_rail
         assign clear_req[g] = wr_fault && req.pwdata[g];
         assign next_irq_set[g] = fall_event && cfg.monitor_en[g] &&
            !valid_sync[g];
         pga_rail_mon u_mon (
            .clock(clock),
            .sys_rst(sys_rst),
            .soft_rst(soft_rst),
            .rail_valid(valid_sync[g]),
            .monitor_en(cfg.monitor_en[g]),
            .fall_event(fall_event),
            .clear_req(clear_req[g]),
            .fault_flag(fault_flags[g])
         );
      end
   endgenerate

   // sticky interrupt status; a new event wins over a write-one clear
   always_comb begin
      irq_set = {good_q && !good, next_irq_set};
      irq_clr = wr_irq_status ? req.pwdata[IRQ_W-1:0] : '0;
   end

   always_ff @(posedge clock) begin
      if (sys_rst || soft_rst) begin
         irq_status <= '0;
      end else begin
         // bits 3:0 follow the rail flags, bit 4 a fall of power good
         irq_status <= irq_set | (irq_status & ~irq_clr);
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         irq <= 1'b0;
      end else begin
         irq <= |(irq_status & irq_mask);
      end
   end

   // pin: polarity flips sense; open drain drives only the low level
   always_comb begin
      next_pin_level = good ^ cfg.polarity;
      next_pin_oe = !ctrl_one[C1_OPEN_DRAIN] || !next_pin_level;
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         power_good_out <= 1'b0;
         power_good_oe <= 1'b1;
      end else begin
         power_good_out <= next_pin_level;
         power_good_oe <= next_pin_oe;
      end
   end

   // read mux; a refused address reads zero whatever index it aliases
   always_comb begin
      next_prdata = 32'h00000000;
      if (is_mapped(req.paddr)) begin
         case (reg_index(req.paddr))
            IDX_CTRL_ONE: next_prdata = {24'h000000, ctrl_one};
            IDX_CTRL_TWO: next_prdata = {24'h000000, ctrl_two};
            IDX_FAULT: next_prdata = {28'h0000000, fault_flags};
            IDX_SOFT_RESET: next_prdata = 32'h00000000;
            IDX_IRQ_STATUS: next_prdata = {27'h0, irq_status};
            IDX_IRQ_MASK: next_prdata = {27'h0, irq_mask};
            IDX_LIVE_STATUS: next_prdata = {26'h0, good_q, twarn_sync,
                                            valid_sync};
            default: next_prdata = 32'h00000000;
         endcase
      end
   end

   // read data registered on the first access cycle, valid with pready
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         prdata <= '0;
      end else if (rd_acc && !pready) begin
         prdata <= next_prdata;
      end
   end
endmodule // pga_power_good
`default_nettype wire

// >>> verif/pga_properties.sv
// checker for the power-good block: apb timing and pin relations
// assumes it is bound to pga_power_good and sees only its ports
`timescale 1ns/100ps
`default_nettype none
module pga_properties
   import pga_pkg::*;
#(
   parameter int RAILS = NUM_RAILS
)(
   input wire logic clock, // clock
   input wire logic sys_rst, // reset
   input wire logic psel, // select
   input wire logic penable, // enable
   input wire logic pwrite, // direction
   input wire logic [31:0] prdata, // read data
   input wire logic pready, // ready
   input wire logic pslverr, // error
   input wire logic [RAILS-1:0] rail_valid, // rails
   input wire logic thermal_warn, // warning
   input wire logic power_good_out, // pin level
   input wire logic power_good_oe, // pin drive
   input wire logic irq // interrupt
);
   default clocking @(posedge clock); endclocking
   default disable iff (sys_rst);
   ready_pulse_a: assert property (pready |=> !pready)
      else $error("pready held too long");
   ready_access_a: assert property (pready |-> psel && penable)
      else $error("pready outside access");
   wait_state_a: assert property (psel && penable && !pready |=> pready)
      else $error("answer late");
   no_early_a: assert property (pready |-> $past(psel && penable))
      else $error("answer early");
   err_with_ready_a: assert property (pslverr |-> pready)
      else $error("pslverr alone");
   read_upper_a: assert property (pready |-> prdata[31:8] == 24'h0)
      else $error("upper read bits set");
   err_read_zero_a: assert property (pslverr && !pwrite |-> prdata == 0)
      else $error("refused read not zero");
   pin_steady_a: assert property (
      (!(psel && pwrite) && $stable(rail_valid) && $stable(thermal_warn))
      [*6] |-> $stable(power_good_out))
      else $error("pin moved without cause");
   released_high_a: assert property (power_good_oe || power_good_out)
      else $error("released pin not high");
   cover property (pslverr);
   cover property ($fell(power_good_out));
   cover property (irq);
endmodule // pga_properties
`default_nettype wire

// >>> verif/pga_host_model.sv
// host-side view of the power-good pin with its board pull-up
// assumes the pin floats to the pull-up whenever the block releases it
`timescale 1ns/100ps
`default_nettype none
module pga_host_model (
   input wire logic power_good_out, // level from block
   input wire logic power_good_oe, // drive enable from block
   output logic pin_level // level the host samples
);
   // a released pin reads the pull-up, never the last driven value
   assign pin_level = power_good_oe ? power_good_out : 1'b1;
endmodule // pga_host_model
`default_nettype wire

// >>> verif/pga_power_good_tb.sv
// self-checking bench for the power-good block over apb
// assumes one wait state per transfer and a pin lag of three edges
`timescale 1ns/100ps
`default_nettype none
module pga_power_good_tb import pga_pkg::*;;
   logic clock = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0;
   logic [ADDR_W-1:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata;
   logic pready, pslverr, power_good_out, power_good_oe, irq, pin_level;
   logic thermal_warn = 0, er;
   logic [3:0] rail_valid = 4'hf;
   logic [7:0] rd;
   int err_total = 0, total_checks = 0, cycles = 0;
   always #2.5 clock = ~clock;
   pga_power_good i_dut (.clock, .sys_rst, .psel, .penable, .pwrite,
      .paddr, .pwdata, .prdata, .pready, .pslverr, .rail_valid,
      .thermal_warn, .power_good_out, .power_good_oe, .irq);
   pga_host_model i_host (.power_good_out, .power_good_oe, .pin_level);
   task automatic wrap_up;
      if (err_total == 0 && total_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, exp);
      total_checks++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] idx, wd);
      int n;
      n = 0;
      @(posedge clock);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {2'h0, idx, 2'h0};
      pwdata <= {24'h0, wd};
      @(posedge clock);
      penable <= 1'b1;
      do begin
         @(posedge clock);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) chk(8'h00, 8'h01);
      rd = prdata[7:0];
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] idx, wd);
      apb(1'b1, idx, wd);
   endtask
   task automatic rdc(input logic [7:0] idx, exp);
      apb(1'b0, idx, 8'h00);
      chk(rd, exp);
   endtask
   task automatic pin(input logic exp);
      repeat (4) @(posedge clock);
      chk(8'(pin_level), 8'(exp));
   endtask
   always @(posedge clock) begin
      cycles++;
      if (cycles == 3000) begin
         err_total++;
         wrap_up;
      end
   end
   initial begin
      repeat (6) @(posedge clock);
      sys_rst <= 1'b0;
      rdc(IDX_CTRL_ONE, 8'h73);
      rdc(IDX_CTRL_TWO, 8'h04);
      rdc(IDX_FAULT, 8'h00);
      pin(1'b1);
      wr(IDX_CTRL_ONE, 8'h0f);
      rail_valid <= 4'hb;
      pin(1'b0);
      rail_valid <= 4'hf;
      pin(1'b1);
      rdc(IDX_FAULT, 8'h04);
      wr(IDX_FAULT, 8'h00);
      rdc(IDX_FAULT, 8'h04);
      rail_valid <= 4'hb;
      wr(IDX_FAULT, 8'h04);
      rdc(IDX_FAULT, 8'h04);
      rail_valid <= 4'hf;
      pin(1'b1);
      wr(IDX_FAULT, 8'hff);
      rdc(IDX_FAULT, 8'h00);
      wr(IDX_CTRL_ONE, 8'h0b);
      rail_valid <= 4'hb;
      pin(1'b1);
      rdc(IDX_FAULT, 8'h00);
      rail_valid <= 4'hf;
      thermal_warn <= 1'b1;
      pin(1'b0);
      wr(IDX_CTRL_TWO, 8'h00);
      pin(1'b1);
      thermal_warn <= 1'b0;
      wr(IDX_CTRL_TWO, 8'h06);
      rail_valid <= 4'he;
      pin(1'b0);
      rail_valid <= 4'hf;
      pin(1'b0);
      rdc(IDX_FAULT, 8'h01);
      wr(IDX_FAULT, 8'h01);
      pin(1'b1);
      chk(8'(irq), 8'h00);
      wr(IDX_IRQ_MASK, 8'h1f);
      repeat (2) @(posedge clock);
      chk(8'(irq), 8'h01);
      wr(IDX_IRQ_STATUS, 8'h1f);
      repeat (2) @(posedge clock);
      chk(8'(irq), 8'h00);
      wr(IDX_CTRL_TWO, 8'hff);
      rdc(IDX_CTRL_TWO, 8'h07);
      wr(IDX_CTRL_ONE, 8'h8f);
      pin(1'b0);
      rdc(IDX_LIVE_STATUS, 8'h2f);
      apb(1'b0, 8'h3f, 8'h00);
      chk(8'(er), 8'h01);
      chk(rd, 8'h00);
      wr(IDX_SOFT_RESET, 8'h01);
      rdc(IDX_CTRL_ONE, 8'h73);
      rdc(IDX_CTRL_TWO, 8'h04);
      rdc(IDX_IRQ_MASK, 8'h00);
      pin(1'b1);
      wrap_up;
   end
endmodule // pga_power_good_tb
bind pga_power_good pga_properties #(.RAILS(RAILS)) i_props (.clock,
   .sys_rst, .psel, .penable, .pwrite, .prdata, .pready, .pslverr,
   .rail_valid, .thermal_warn, .power_good_out, .power_good_oe, .irq);
`default_nettype wire
